// >>> src/lstl_pkg.sv
// lstl_pkg: shared constants for the led set-point and thermal limit register bank.
// assumes a single 250 MHz core clock and a 4-bit register index from the frame decoder.
package lstl_pkg;

	// register geometry
	localparam int          REG_W      = 9;          // every register is nine bits wide
	localparam int          FIELD_W    = 8;          // low byte is the read-write field
	localparam int          ADDR_W     = 4;          // register index width
	localparam int          RSVD_BIT   = 8;          // reserved bit position, reads zero

	// register indices
	localparam logic [3:0]  ADDR_THERM_LIMIT = 4'h2; // thermal warning limit
	localparam logic [3:0]  ADDR_CH1_PEAK    = 4'h3; // channel 1 peak threshold
	localparam logic [3:0]  ADDR_CH2_PEAK    = 4'h4; // channel 2 peak threshold
	localparam logic [3:0]  ADDR_CH1_OFFTIME = 4'h5; // channel 1 off-time setting
	localparam logic [3:0]  ADDR_DIE_TEMP    = 4'h9; // latest thermal conversion

	// reset values
	localparam logic [7:0]  SETPOINT_RST  = 8'h80;   // all set points come up mid-scale
	localparam logic [7:0]  DIE_TEMP_RST  = 8'h00;   // no conversion yet
	localparam logic [8:0]  READ_ZERO     = 9'h000;  // unmapped and reserved answer

	// peak code is millivolts across the sense resistor
	localparam int          MV_PER_VOLT   = 1000;

	// dac settle bound: longest time rounds down to whole cycles
	localparam int          CLK_MHZ         = 250;
	localparam int          DAC_UPDATE_NS   = 1000;
	localparam int          DAC_UPDATE_CYC  = (DAC_UPDATE_NS * CLK_MHZ) / 1000;
	localparam int          DAC_LATENCY_CYC = 1;     // cycles from set-point register to dac code

endpackage : lstl_pkg

// >>> src/lstl_dac_update.sv
// lstl_dac_update: carries one set-point register into the analog dac code port.
// assumes the dac samples dac_code whenever dac_load pulses; the code is held between loads.
`timescale 1ns/1ps

module lstl_dac_update #(
	parameter int UPDATE_CYC = lstl_pkg::DAC_UPDATE_CYC // bound the load must meet
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] setpoint,
	output logic      [7:0] dac_code,
	output logic            dac_load
);

	logic [7:0] code_q;  // code presented to the dac
	logic [7:0] code_d;
	logic       load_q;  // one-cycle strobe when the code moves
	logic       load_d;

	// a changed set point is copied on the next edge, well inside the bound
	always_comb begin
		code_d = setpoint;
		load_d = (setpoint != code_q) && (lstl_pkg::DAC_LATENCY_CYC <= UPDATE_CYC);
	end

	// registers only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			code_q <= lstl_pkg::SETPOINT_RST;
			load_q <= 1'b0;
		end else begin
			code_q <= code_d;
			load_q <= load_d;
		end
	end

	assign dac_code = code_q;
	assign dac_load = load_q;

endmodule : lstl_dac_update

// >>> src/lstl_regs.sv
// lstl_regs: thermal warning limit, peak threshold and off-time set-point registers.
// assumes the frame decoder hands over one-cycle read and write strobes with a register
// index, and that the thermal converter pulses a valid strobe with each new reading.
//
// Operation
// - thermal limit at 02h, byte field, reset 80h
// - reading above limit sets latched thermal flag
// - bit 8 reserved reads zero, bits 7-0 writable
// - channel 1 peak set point at 03h, reset 80h
// - channel 2 peak set point at 04h, reset 80h
// - channel 1 off-time at 05h feeds dac
// - peak rewrites reach dac within one microsecond
// - peak code means trip millivolts, value/1000 volts
// - on-time ends when sense reaches peak set point
// - flag clears on status read once condition gone
// - latest thermal conversion readable at 09h
`timescale 1ns/1ps

module lstl_regs #(
	parameter int ADDR_W  = lstl_pkg::ADDR_W,  // register index width
	parameter int REG_W   = lstl_pkg::REG_W,   // register width on the access port
	parameter int FIELD_W = lstl_pkg::FIELD_W  // writable field width
) (
	input  wire logic               core_clk,
	input  wire logic               rst,
	// register access from the frame decoder
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [REG_W-1:0]   reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [REG_W-1:0]   reg_rdata,
	output logic                    reg_rvalid,
	// status register read strobe and the latched flag shown there
	input  wire logic               status_rd,
	output logic                    thermal_warn_flag,
	// thermal converter
	input  wire logic [FIELD_W-1:0] die_temp_reading,
	input  wire logic               die_temp_valid,
	// peak comparators, sense voltage coded in millivolts
	input  wire logic [FIELD_W-1:0] ch1_sense_mv,
	input  wire logic [FIELD_W-1:0] ch2_sense_mv,
	output logic                    ch1_ontime_end,
	output logic                    ch2_ontime_end,
	// dac codes
	output logic      [FIELD_W-1:0] ch1_peak_dac,
	output logic                    ch1_peak_dac_load,
	output logic      [FIELD_W-1:0] ch2_peak_dac,
	output logic                    ch2_peak_dac_load,
	output logic      [FIELD_W-1:0] ch1_offtime_dac,
	output logic                    ch1_offtime_dac_load
);

	// unsigned strictly-greater compare shared by set and clear paths
	function automatic logic lstl_exceeds(input logic [7:0] reading, input logic [7:0] limit);
		lstl_exceeds = (reading > limit);
	endfunction : lstl_exceeds

	// set-point registers
	logic [7:0] thermal_limit_value_q;   // warning limit
	logic [7:0] thermal_limit_value_d;
	logic [7:0] ch1_peak_setpoint_q;     // channel 1 peak trip, millivolts
	logic [7:0] ch1_peak_setpoint_d;
	logic [7:0] ch2_peak_setpoint_q;     // channel 2 peak trip, millivolts
	logic [7:0] ch2_peak_setpoint_d;
	logic [7:0] ch1_offtime_setpoint_q;  // channel 1 off-time product
	logic [7:0] ch1_offtime_setpoint_d;

	// thermal state
	logic [7:0] die_temp_q;              // latest conversion
	logic [7:0] die_temp_d;
	logic       warn_q;                  // latched warning flag
	logic       warn_d;
	logic       warn_set;                // new conversion over the limit
	logic       cond_present;            // stored reading still over the limit

	// read port
	logic [8:0] rdata_q;
	logic [8:0] rdata_d;
	logic       rvalid_q;
	logic       rvalid_d;

	// comparator outputs are registered so they do not glitch on sense noise
	logic       ch1_end_q;
	logic       ch1_end_d;
	logic       ch2_end_q;
	logic       ch2_end_d;

	// write decode: only the low byte is stored, bit 8 of write data is dropped
	always_comb begin
		thermal_limit_value_d  = thermal_limit_value_q;
		ch1_peak_setpoint_d    = ch1_peak_setpoint_q;
		ch2_peak_setpoint_d    = ch2_peak_setpoint_q;
		ch1_offtime_setpoint_d = ch1_offtime_setpoint_q;
		if (reg_wr) begin
			if (reg_addr == lstl_pkg::ADDR_THERM_LIMIT) begin
				thermal_limit_value_d = reg_wdata[7:0];
			end else if (reg_addr == lstl_pkg::ADDR_CH1_PEAK) begin
				ch1_peak_setpoint_d = reg_wdata[7:0];
			end else if (reg_addr == lstl_pkg::ADDR_CH2_PEAK) begin
				ch2_peak_setpoint_d = reg_wdata[7:0];
			end else if (reg_addr == lstl_pkg::ADDR_CH1_OFFTIME) begin
				ch1_offtime_setpoint_d = reg_wdata[7:0];
			end
			// the reading register and unmapped indices ignore writes
		end
	end

	// set points register; a write may land at any time during operation
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			thermal_limit_value_q  <= lstl_pkg::SETPOINT_RST;
			ch1_peak_setpoint_q    <= lstl_pkg::SETPOINT_RST;
			ch2_peak_setpoint_q    <= lstl_pkg::SETPOINT_RST;
			ch1_offtime_setpoint_q <= lstl_pkg::SETPOINT_RST;
		end else begin
			thermal_limit_value_q  <= thermal_limit_value_d;
			ch1_peak_setpoint_q    <= ch1_peak_setpoint_d;
			ch2_peak_setpoint_q    <= ch2_peak_setpoint_d;
			ch1_offtime_setpoint_q <= ch1_offtime_setpoint_d;
		end
	end

	// thermal reading capture and latched warning
	always_comb begin
		die_temp_d   = die_temp_q;
		if (die_temp_valid) begin
			die_temp_d = die_temp_reading;
		end
		// compare against the limit in force when the conversion arrives
		warn_set     = die_temp_valid &&
			lstl_exceeds(die_temp_reading, thermal_limit_value_q);
		// the stored reading decides whether the condition still holds;
		// a limit raised above it lets the next status read clear the flag
		cond_present = lstl_exceeds(die_temp_q, thermal_limit_value_q);
		warn_d       = warn_q;
		if (warn_set) begin
			warn_d = 1'b1;
		end else if (status_rd && !cond_present) begin
			warn_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			die_temp_q <= lstl_pkg::DIE_TEMP_RST;
			warn_q     <= 1'b0;
		end else begin
			die_temp_q <= die_temp_d;
			warn_q     <= warn_d;
		end
	end

	// read mux: answer one cycle after the strobe, unmapped reads return zero
	always_comb begin
		rvalid_d = reg_rd;
		rdata_d  = lstl_pkg::READ_ZERO;
		if (reg_rd) begin
			if (reg_addr == lstl_pkg::ADDR_THERM_LIMIT) begin
				rdata_d = {1'b0, thermal_limit_value_q};
			end else if (reg_addr == lstl_pkg::ADDR_CH1_PEAK) begin
				rdata_d = {1'b0, ch1_peak_setpoint_q};
			end else if (reg_addr == lstl_pkg::ADDR_CH2_PEAK) begin
				rdata_d = {1'b0, ch2_peak_setpoint_q};
			end else if (reg_addr == lstl_pkg::ADDR_CH1_OFFTIME) begin
				rdata_d = {1'b0, ch1_offtime_setpoint_q};
			end else if (reg_addr == lstl_pkg::ADDR_DIE_TEMP) begin
				rdata_d = {1'b0, die_temp_q};
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q  <= lstl_pkg::READ_ZERO;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// peak trip: sense millivolts reaching the programmed code ends on-time.
	// the code is read directly as millivolts, so no scaling sits here; small
	// codes trip with more relative spread, which is why hosts use high codes
	always_comb begin
		ch1_end_d = (ch1_sense_mv >= ch1_peak_dac);
		ch2_end_d = (ch2_sense_mv >= ch2_peak_dac);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ch1_end_q <= 1'b0;
			ch2_end_q <= 1'b0;
		end else begin
			ch1_end_q <= ch1_end_d;
			ch2_end_q <= ch2_end_d;
		end
	end

	// dac hand-off for the two peak and the off-time set points
	lstl_dac_update #(
		.UPDATE_CYC (lstl_pkg::DAC_UPDATE_CYC)
	) u_ch1_peak (
		.core_clk (core_clk),
		.rst      (rst),
		.setpoint (ch1_peak_setpoint_q),
		.dac_code (ch1_peak_dac),
		.dac_load (ch1_peak_dac_load)
	);

	lstl_dac_update #(
		.UPDATE_CYC (lstl_pkg::DAC_UPDATE_CYC)
	) u_ch2_peak (
		.core_clk (core_clk),
		.rst      (rst),
		.setpoint (ch2_peak_setpoint_q),
		.dac_code (ch2_peak_dac),
		.dac_load (ch2_peak_dac_load)
	);

	lstl_dac_update #(
		.UPDATE_CYC (lstl_pkg::DAC_UPDATE_CYC)
	) u_ch1_offtime (
		.core_clk (core_clk),
		.rst      (rst),
		.setpoint (ch1_offtime_setpoint_q),
		.dac_code (ch1_offtime_dac),
		.dac_load (ch1_offtime_dac_load)
	);

	// outputs
	assign reg_rdata         = rdata_q;
	assign reg_rvalid        = rvalid_q;
	assign thermal_warn_flag = warn_q;
	assign ch1_ontime_end    = ch1_end_q;
	assign ch2_ontime_end    = ch2_end_q;

endmodule : lstl_regs

// >>> verif/lstl_regs_checker.sv
// lstl_regs_checker: port-level properties of the set-point bank.
// assumes it is bound into lstl_regs and sees only its ports.
`timescale 1ns/1ps

module lstl_regs_checker (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [3:0] reg_addr,
	input wire logic [8:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [8:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       status_rd,
	input wire logic       thermal_warn_flag,
	input wire logic [7:0] die_temp_reading,
	input wire logic       die_temp_valid,
	input wire logic [7:0] ch1_sense_mv,
	input wire logic       ch1_ontime_end,
	input wire logic [7:0] ch1_peak_dac,
	input wire logic       ch1_peak_dac_load,
	input wire logic [7:0] ch2_peak_dac,
	input wire logic [7:0] ch1_offtime_dac,
	input wire logic       ch2_peak_dac_load,
	input wire logic       ch1_offtime_dac_load
);
	logic [7:0] lim_q; // shadow of the limit, since it is not a port
	logic [7:0] lim_d; // next shadow value
	// follow limit writes; bit 8 never reaches the field
	always_comb begin
		lim_d = lim_q;
		if (reg_wr && reg_addr == lstl_pkg::ADDR_THERM_LIMIT) begin
			lim_d = reg_wdata[7:0];
		end
	end
	// shadow register, same reset as the bank
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lim_q <= lstl_pkg::SETPOINT_RST;
		end else begin
			lim_q <= lim_d;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// a write strobe aimed at one index
	sequence s_wr(logic [3:0] a);
		reg_wr && reg_addr == a;
	endsequence
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe got no answer");
	a_idle_quiet: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 9'h000)
		else $error("read answer without a read");
	a_rsvd_zero: assert property (reg_rvalid |-> !reg_rdata[8])
		else $error("reserved bit read as one");
	a_ch1_dac: assert property (s_wr(lstl_pkg::ADDR_CH1_PEAK) |-> ##2
		ch1_peak_dac == $past(reg_wdata[7:0], 2)) else $error("ch1 peak code late");
	a_ch2_dac: assert property (s_wr(lstl_pkg::ADDR_CH2_PEAK) |-> ##2
		ch2_peak_dac == $past(reg_wdata[7:0], 2)) else $error("ch2 peak code late");
	a_off_dac: assert property (s_wr(lstl_pkg::ADDR_CH1_OFFTIME) |-> ##2
		ch1_offtime_dac == $past(reg_wdata[7:0], 2)) else $error("off-time code late");
	a_load_mark: assert property (ch1_peak_dac_load == $changed(ch1_peak_dac))
		else $error("ch1 load does not match code change");
	a_load_ch2: assert property (ch2_peak_dac_load == $changed(ch2_peak_dac))
		else $error("ch2 load does not match code change");
	a_load_off: assert property (ch1_offtime_dac_load == $changed(ch1_offtime_dac))
		else $error("off-time load does not match code change");
	a_warn_set: assert property (die_temp_valid && die_temp_reading > lim_q
		|=> thermal_warn_flag) else $error("hot reading not flagged");
	a_warn_hold: assert property (thermal_warn_flag && !status_rd |=> thermal_warn_flag)
		else $error("flag dropped without status read");
	a_trip_ch1: assert property (!$past(rst) |-> ch1_ontime_end ==
		($past(ch1_sense_mv) >= $past(ch1_peak_dac))) else $error("ch1 trip wrong");
endmodule : lstl_regs_checker

bind lstl_regs lstl_regs_checker u_chk (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .reg_rvalid, .status_rd, .thermal_warn_flag, .die_temp_reading,
	.die_temp_valid, .ch1_sense_mv, .ch1_ontime_end, .ch1_peak_dac, .ch1_peak_dac_load,
	.ch2_peak_dac, .ch1_offtime_dac, .ch2_peak_dac_load, .ch1_offtime_dac_load);

// >>> verif/lstl_host_model.sv
// lstl_host_model: host side of the register port, one request per call.
// assumes requests launch 1 ns after a rising core_clk edge.
`timescale 1ns/1ps

module lstl_host_model (
	input  wire logic       core_clk,
	output logic      [3:0] reg_addr,
	output logic      [8:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic            status_rd
);
	// idle port at time zero
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 9'h000;
		{status_rd, reg_rd, reg_wr} = 3'b000;
	end
	// kind: bit 0 write, bit 1 read, bit 2 status read; one-cycle strobe
	task automatic acc(input logic [2:0] kind, input logic [3:0] a, input logic [8:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		{status_rd, reg_rd, reg_wr} = kind;
		@(posedge core_clk);
		#1;
		{status_rd, reg_rd, reg_wr} = 3'b000;
		reg_wdata = ~d; // released data must not look valid
	endtask : acc
endmodule : lstl_host_model

// >>> verif/tb_top.sv
// tb_top: self-checking bench for the set-point and thermal bank.
// assumes the host model owns the register strobes.
`timescale 1ns/1ps

module tb_top;
	logic       core_clk, rst, reg_wr, reg_rd, status_rd, reg_rvalid;
	logic       thermal_warn_flag, die_temp_valid, ch1_ontime_end, ch2_ontime_end;
	logic       ch1_peak_dac_load, ch2_peak_dac_load, ch1_offtime_dac_load;
	logic [3:0] reg_addr;
	logic [8:0] reg_wdata, reg_rdata;
	logic [7:0] die_temp_reading, ch1_sense_mv, ch2_sense_mv, lim;
	logic [7:0] ch1_peak_dac, ch2_peak_dac, ch1_offtime_dac;
	logic [7:0] v[4];      // random set points for indices 2 to 5
	logic [8:0] exp_q[$];  // expected read answers, oldest first
	int         failures = 0, cmp_count = 0, cyc = 0;

	lstl_regs u_lstl_regs (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .reg_rvalid, .status_rd, .thermal_warn_flag, .die_temp_reading,
		.die_temp_valid, .ch1_sense_mv, .ch2_sense_mv, .ch1_ontime_end, .ch2_ontime_end,
		.ch1_peak_dac, .ch1_peak_dac_load, .ch2_peak_dac, .ch2_peak_dac_load,
		.ch1_offtime_dac, .ch1_offtime_dac_load);
	lstl_host_model u_lstl_host_model (.core_clk, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .status_rd);

	// 250 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic chk_out(input logic [8:0] got, input logic [8:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk_out
	task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
		chk_out(got, exp);
	endtask : chk_rd
	task automatic end_of_test();
		// a read that never answered leaves its note behind
		if (exp_q.size() != 0) begin
			failures++;
			$display("wrong value at %0t: %0d read answers missing", $time, exp_q.size());
		end
		$display("compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	// note the answer first, then issue the read
	task automatic rd(input logic [3:0] a, input logic [8:0] e);
		exp_q.push_back(e);
		u_lstl_host_model.acc(3'b010, a, 9'h000);
	endtask : rd
	// one conversion strobe; data is scrambled once it is no longer valid
	task automatic temp(input logic [7:0] r);
		@(posedge core_clk);
		#1;
		die_temp_reading = r;
		die_temp_valid = 1'b1;
		@(posedge core_clk);
		#1;
		die_temp_valid = 1'b0;
		die_temp_reading = ~r;
	endtask : temp
	// answers are settled by the falling edge; an empty queue is a stray answer
	always @(negedge core_clk) begin
		if (reg_rvalid === 1'b1) begin
			chk_rd(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff);
		end
	end
	// hang guard, far beyond the sixty or so cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		rst = 1'b1;
		die_temp_reading = 8'h00;
		die_temp_valid = 1'b0;
		ch1_sense_mv = 8'h00;
		ch2_sense_mv = 8'h00;
		void'($urandom(32'had72));
		repeat (2) @(posedge core_clk);
		#1 rst = 1'b0;
		// reset values, then the read-only reading and two holes
		rd(4'h2, 9'h080);
		rd(4'h3, 9'h080);
		rd(4'h4, 9'h080);
		rd(4'h5, 9'h080);
		rd(4'h9, 9'h000);
		rd(4'h0, 9'h000);
		rd(4'hf, 9'h000);
		// random set points with bit 8 set; writing the reading must do nothing
		for (int i = 0; i < 4; i++) begin
			v[i] = 8'($urandom_range(255, 1));
			u_lstl_host_model.acc(3'b001, 4'(i + 2), {1'b1, v[i]});
		end
		u_lstl_host_model.acc(3'b001, 4'h9, 9'h1ff);
		for (int i = 0; i < 4; i++) rd(4'(i + 2), {1'b0, v[i]});
		rd(4'h9, 9'h000);
		chk_out({1'b0, ch1_peak_dac}, {1'b0, v[1]});
		chk_out({1'b0, ch2_peak_dac}, {1'b0, v[2]});
		chk_out({1'b0, ch1_offtime_dac}, {1'b0, v[3]});
		// equal reading is quiet, one above warns and survives a hot status read
		lim = 8'($urandom_range(253, 0));
		u_lstl_host_model.acc(3'b001, 4'h2, {1'b0, lim});
		temp(lim);
		chk_out({8'h00, thermal_warn_flag}, 9'h000);
		temp(lim + 8'h01);
		chk_out({8'h00, thermal_warn_flag}, 9'h001);
		u_lstl_host_model.acc(3'b100, 4'h1, 9'h000);
		chk_out({8'h00, thermal_warn_flag}, 9'h001);
		rd(4'h9, {1'b0, lim + 8'h01});
		u_lstl_host_model.acc(3'b001, 4'h2, 9'h0ff);
		u_lstl_host_model.acc(3'b100, 4'h1, 9'h000);
		chk_out({8'h00, thermal_warn_flag}, 9'h000);
		// highest peak code; one millivolt short, then reaching the code
		u_lstl_host_model.acc(3'b001, 4'h3, 9'h0ff);
		ch1_sense_mv = 8'hfe;
		ch2_sense_mv = v[2] - 8'h01;
		repeat (3) @(posedge core_clk);
		#1;
		chk_out({7'h00, ch2_ontime_end, ch1_ontime_end}, 9'h000);
		ch1_sense_mv = 8'hff;
		ch2_sense_mv = v[2];
		repeat (2) @(posedge core_clk);
		#1;
		chk_out({7'h00, ch2_ontime_end, ch1_ontime_end}, 9'h003);
		end_of_test();
	end
endmodule : tb_top
